// File: logic/alu_core.sv
// Four-phase execution core for add-with-carry and the two AND forms
`timescale 1ns/1ps
module alu_core (
  input wire logic i_mclk,
  input wire logic i_rst,
  input wire logic i_instr_valid,
  input wire alu_pkg::instr_t i_instr,
  input wire logic i_ext_en,
  input wire logic [alu_pkg::BANK_W-1:0] i_bank_select,
  input wire logic [alu_pkg::DMEM_AW-1:0] i_fsr2,
  input wire logic [7:0] i_mem_rdata,
  input wire logic i_preset,
  input wire logic [7:0] i_preset_w,
  input wire alu_pkg::status_t i_preset_status,
  output logic o_instr_ready,
  output logic o_done,
  output alu_pkg::mem_req_t o_mem,
  output logic [7:0] o_w,
  output alu_pkg::status_t o_status
);

  // ****************************************
  // Phase sequencer
  // ****************************************
  typedef enum logic [1:0] {
    PH_DECODE,
    PH_READ,
    PH_PROCESS,
    PH_WRITE
  } phase_t;

  phase_t phase_q, phase_d;

  // The phases run free so every instruction takes exactly four clocks
  always_comb begin
    case (phase_q)
      PH_DECODE: phase_d = PH_READ; // RQ8
      PH_READ: phase_d = PH_PROCESS; // RQ8
      PH_PROCESS: phase_d = PH_WRITE; // RQ8
      PH_WRITE: phase_d = PH_DECODE; // RQ8
      default: phase_d = PH_DECODE;
    endcase
  end

  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      phase_q <= PH_DECODE;
    end else begin
      phase_q <= phase_d;
    end
  end

  // ****************************************
  // Datapath state
  // ****************************************
  alu_pkg::op_t op_q, op_d;
  alu_pkg::instr_t ins_q, ins_d;
  alu_pkg::status_t stat_q, stat_d;
  alu_pkg::status_t rstat_q, rstat_d;
  alu_pkg::status_t alu_stat;
  logic [alu_pkg::DMEM_AW-1:0] addr_q, addr_d;
  logic [7:0] w_q, w_d;
  logic [7:0] opnd_q, opnd_d;
  logic [7:0] res_q, res_d;
  logic [7:0] alu_res;

  function automatic logic [alu_pkg::DMEM_AW-1:0] file_addr(
    input alu_pkg::instr_t ins,
    input logic ext_en,
    input logic [alu_pkg::BANK_W-1:0] bank,
    input logic [alu_pkg::DMEM_AW-1:0] fsr2
  );
    logic [alu_pkg::DMEM_AW-1:0] ad;
    ad = {alu_pkg::ACCESS_LO_BANK, ins.f};
    if (ins.a) begin
      ad = {bank, ins.f}; // RQ3
    end else if (ext_en && ins.f <= alu_pkg::INDEXED_LIMIT) begin
      // Offset wraps within data space rather than faulting
      ad = fsr2 + {{(alu_pkg::DMEM_AW-8){1'b0}}, ins.f}; // RQ4
    end else if (ins.f < alu_pkg::ACCESS_SPLIT) begin
      ad = {alu_pkg::ACCESS_LO_BANK, ins.f}; // RQ3
    end else begin
      ad = {alu_pkg::ACCESS_HI_BANK, ins.f}; // RQ3
    end
    return ad;
  endfunction

  alu_unit u_alu (
    .i_op(op_q),
    .i_acc(w_q),
    .i_opnd(opnd_q),
    .i_status(stat_q),
    .o_result(alu_res),
    .o_status(alu_stat)
  );

  always_comb begin
    op_d = op_q;
    ins_d = ins_q;
    addr_d = addr_q;
    w_d = w_q;
    stat_d = stat_q;
    opnd_d = opnd_q;
    res_d = res_q;
    rstat_d = rstat_q;
    case (phase_q)
      PH_DECODE: begin
        op_d = alu_pkg::OP_NONE;
        if (i_instr_valid) begin
          ins_d = i_instr;
          op_d = alu_pkg::decode(i_instr); // RQ1 RQ5 RQ6
          addr_d = file_addr(i_instr, i_ext_en, i_bank_select, i_fsr2);
        end else if (i_preset) begin
          w_d = i_preset_w;
          stat_d = i_preset_status;
        end
      end
      PH_READ: begin
        if (alu_pkg::is_file_op(op_q)) begin
          opnd_d = i_mem_rdata; // RQ7
        end else begin
          opnd_d = ins_q.f; // RQ5
        end
      end
      PH_PROCESS: begin
        res_d = alu_res;
        rstat_d = alu_stat;
      end
      PH_WRITE: begin
        if (op_q != alu_pkg::OP_NONE) begin
          stat_d = rstat_q;
          if (op_q == alu_pkg::OP_AND_LIT || !ins_q.d) begin
            w_d = res_q; // RQ2 RQ5
          end
        end
      end
      default: begin
        op_d = alu_pkg::OP_NONE;
      end
    endcase
  end

  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      op_q <= alu_pkg::OP_NONE;
      ins_q <= '0;
      addr_q <= '0;
      w_q <= alu_pkg::W_RESET;
      stat_q <= alu_pkg::STATUS_RESET;
      opnd_q <= 8'h00;
      res_q <= 8'h00;
      rstat_q <= alu_pkg::STATUS_RESET;
    end else begin
      op_q <= op_d;
      ins_q <= ins_d;
      addr_q <= addr_d;
      w_q <= w_d;
      stat_q <= stat_d;
      opnd_q <= opnd_d;
      res_q <= res_d;
      rstat_q <= rstat_d;
    end
  end

  // ****************************************
  // Outputs
  // ****************************************
  logic file_op;

  always_comb begin
    file_op = alu_pkg::is_file_op(op_q);
    o_instr_ready = (phase_q == PH_DECODE);
    o_done = (phase_q == PH_WRITE) && (op_q != alu_pkg::OP_NONE); // RQ8
    o_mem.addr = addr_q;
    o_mem.wdata = res_q;
    o_mem.rd = (phase_q == PH_READ) && file_op;
    o_mem.wr = (phase_q == PH_WRITE) && file_op && ins_q.d; // RQ2 RQ7
    o_w = w_q;
    o_status = stat_q;
  end

  // ****************************************
  // Checks
  // ****************************************
  default clocking cb @(posedge i_mclk);
  endclocking
  default disable iff (i_rst);

  logic take;
  alu_pkg::op_t take_op;
  assign take = o_instr_ready && i_instr_valid;
  assign take_op = alu_pkg::decode(i_instr);

  chk_four_phase: assert property ( // RQ8
    take && take_op != alu_pkg::OP_NONE |-> ##3 o_done ##1 o_instr_ready)
    else $error("instruction did not finish in four phases");

  chk_add_sum: assert property ( // RQ1
    phase_q == PH_PROCESS && op_q == alu_pkg::OP_ADD_CARRY |=>
      {rstat_q.c, res_q} == {1'b0, $past(w_q)} + {1'b0, $past(opnd_q)}
        + {8'h00, $past(stat_q.c)})
    else $error("add with carry sum or carry wrong");

  chk_dest_file: assert property ( // RQ2
    phase_q == PH_WRITE && file_op && ins_q.d |->
      o_mem.wr && o_mem.wdata == res_q ##1 $stable(w_q))
    else $error("file destination not written to memory");

  chk_dest_acc: assert property ( // RQ2
    phase_q == PH_WRITE && file_op && !ins_q.d |->
      !o_mem.wr ##1 w_q == $past(res_q))
    else $error("accumulator destination not written");

  chk_bank_reg: assert property ( // RQ3
    take && alu_pkg::is_file_op(take_op) && i_instr.a |=>
      o_mem.addr == {$past(i_bank_select), $past(i_instr.f)} ##0 o_mem.rd)
    else $error("banked address wrong");

  chk_indexed_mode: assert property ( // RQ4
    take && alu_pkg::is_file_op(take_op) && !i_instr.a && i_ext_en
      && i_instr.f <= alu_pkg::INDEXED_LIMIT |=>
      o_mem.addr == $past(i_fsr2)
        + {alu_pkg::ACCESS_LO_BANK, $past(i_instr.f)})
    else $error("indexed literal offset address wrong");

  chk_access_low: assert property ( // RQ3
    take && alu_pkg::is_file_op(take_op) && !i_instr.a && !i_ext_en
      && i_instr.f < alu_pkg::ACCESS_SPLIT |=>
      o_mem.addr == {alu_pkg::ACCESS_LO_BANK, $past(i_instr.f)})
    else $error("access bank address wrong");

  chk_and_lit: assert property ( // RQ5
    take && take_op == alu_pkg::OP_AND_LIT |-> ##4
      w_q == ($past(w_q, 4) & $past(i_instr.f, 4))
      && stat_q.c == $past(stat_q.c, 4) && stat_q.ov == $past(stat_q.ov, 4)
      && stat_q.dc == $past(stat_q.dc, 4) && stat_q.z == (w_q == 8'h00))
    else $error("and literal result or flags wrong");

  chk_and_file_flags: assert property ( // RQ6
    phase_q == PH_WRITE && op_q == alu_pkg::OP_AND_FILE |=>
      $stable(stat_q.c) && $stable(stat_q.dc) && $stable(stat_q.ov)
      && stat_q.n == $past(res_q[7]))
    else $error("and file flags wrong");

  cov_add_carry: cover property (
    phase_q == PH_WRITE && op_q == alu_pkg::OP_ADD_CARRY && stat_q.c);
  cov_and_lit: cover property (
    phase_q == PH_WRITE && op_q == alu_pkg::OP_AND_LIT);
  cov_and_file_mem: cover property (
    o_mem.wr && op_q == alu_pkg::OP_AND_FILE);
  cov_indexed: cover property (
    take && i_ext_en && !i_instr.a && i_instr.f <= alu_pkg::INDEXED_LIMIT);

endmodule

// File: logic/alu_pkg.sv
// Shared constants, types and decode helpers for the add/and datapath
// Summary of operation
// (RQ1) Add acc, file byte, carry; update five flags
// (RQ2) Destination bit selects accumulator or file byte
// (RQ3) Bank bit selects access bank or bank register
// (RQ4) Extended set, low addresses use indexed offset
// (RQ5) Literal AND into accumulator; only N, Z
// (RQ6) Accumulator AND file byte; only N, Z
// (RQ7) Full 8-bit file address; result to memory
// (RQ8) One word, one cycle of four phases
package alu_pkg;

  localparam int DMEM_AW = 12;
  localparam int BANK_W = DMEM_AW - 8;

  // ****************************************
  // Encodings
  // ****************************************
  localparam logic [5:0] OPC_ADD_CARRY = 6'h08;
  localparam logic [5:0] OPC_AND_FILE = 6'h05;
  localparam logic [7:0] OPC_AND_LIT = 8'h0b;

  // ****************************************
  // Addressing
  // ****************************************
  localparam logic [7:0] INDEXED_LIMIT = 8'h5f;
  localparam logic [7:0] ACCESS_SPLIT = 8'h60;
  localparam logic [BANK_W-1:0] ACCESS_LO_BANK = 4'h0;
  localparam logic [BANK_W-1:0] ACCESS_HI_BANK = 4'hf;

  localparam logic [7:0] W_RESET = 8'h00;

  typedef enum logic [1:0] {
    OP_NONE,
    OP_ADD_CARRY,
    OP_AND_LIT,
    OP_AND_FILE
  } op_t;

  typedef struct packed {
    logic [5:0] opc;
    logic d;
    logic a;
    logic [7:0] f;
  } instr_t;

  typedef struct packed {
    logic n;
    logic ov;
    logic z;
    logic dc;
    logic c;
  } status_t;

  localparam status_t STATUS_RESET = 5'h00;

  typedef struct packed {
    logic [DMEM_AW-1:0] addr;
    logic [7:0] wdata;
    logic rd;
    logic wr;
  } mem_req_t;

  function automatic op_t decode(input instr_t ins);
    op_t op;
    op = OP_NONE;
    if (ins.opc == OPC_ADD_CARRY) begin
      op = OP_ADD_CARRY;
    end else if (ins.opc == OPC_AND_FILE) begin
      op = OP_AND_FILE;
    end else if ({ins.opc, ins.d, ins.a} == OPC_AND_LIT) begin
      op = OP_AND_LIT;
    end
    return op;
  endfunction

  function automatic logic is_file_op(input op_t op);
    return (op == OP_ADD_CARRY) || (op == OP_AND_FILE);
  endfunction

endpackage

// File: logic/alu_unit.sv
// Combinational arithmetic and logic stage with flag generation
`timescale 1ns/1ps
module alu_unit (
  input wire alu_pkg::op_t i_op,
  input wire logic [7:0] i_acc,
  input wire logic [7:0] i_opnd,
  input wire alu_pkg::status_t i_status,
  output logic [7:0] o_result,
  output alu_pkg::status_t o_status
);

  logic [8:0] sum;
  logic [4:0] low_sum;

  always_comb begin
    sum = {1'b0, i_acc} + {1'b0, i_opnd} + {8'h00, i_status.c};
    low_sum = {1'b0, i_acc[3:0]} + {1'b0, i_opnd[3:0]}
      + {4'h0, i_status.c};
    o_status = i_status;
    o_result = i_acc;
    case (i_op)
      alu_pkg::OP_ADD_CARRY: begin
        o_result = sum[7:0]; // RQ1
        o_status.c = sum[8]; // RQ1
        o_status.dc = low_sum[4]; // RQ1
        // Signed overflow: like-signed operands, result sign flips
        o_status.ov = (i_acc[7] == i_opnd[7]) && (sum[7] != i_acc[7]);
      end
      alu_pkg::OP_AND_LIT, alu_pkg::OP_AND_FILE: begin
        o_result = i_acc & i_opnd; // RQ5 RQ6
      end
      default: begin
        o_result = i_acc;
      end
    endcase
    // Only N and Z move for the AND forms; C, DC, OV keep their value
    o_status.n = o_result[7]; // RQ1 RQ5 RQ6
    o_status.z = (o_result == 8'h00); // RQ1 RQ5 RQ6
    if (i_op == alu_pkg::OP_NONE) begin
      o_status = i_status;
    end
  end

endmodule

// File: testbench/testbench.sv
// Self-checking bench for the add-with-carry and AND execution core
`timescale 1ns/1ps
module testbench;
  logic i_mclk, i_rst, i_instr_valid, i_ext_en, i_preset;
  alu_pkg::instr_t i_instr;
  logic [alu_pkg::BANK_W-1:0] i_bank_select;
  logic [alu_pkg::DMEM_AW-1:0] i_fsr2;
  logic [7:0] i_mem_rdata, i_preset_w, o_w;
  alu_pkg::status_t i_preset_status, o_status;
  logic o_instr_ready, o_done;
  alu_pkg::mem_req_t o_mem;
  int n_errors = 0;
  int n_tests = 0;
  logic [12:0] x;

  alu_core DUT (.i_mclk(i_mclk), .i_rst(i_rst),
    .i_instr_valid(i_instr_valid), .i_instr(i_instr),
    .i_ext_en(i_ext_en), .i_bank_select(i_bank_select),
    .i_fsr2(i_fsr2), .i_mem_rdata(i_mem_rdata), .i_preset(i_preset),
    .i_preset_w(i_preset_w), .i_preset_status(i_preset_status),
    .o_instr_ready(o_instr_ready), .o_done(o_done), .o_mem(o_mem),
    .o_w(o_w), .o_status(o_status));

  // ****************************************
  // Helpers
  // ****************************************
  task automatic give_verdict;
    $display("errors %0d checks %0d", n_errors, n_tests);
    if (n_errors == 0 && n_tests > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  task automatic check(input logic [15:0] seen, exp, input string msg);
    n_tests++;
    if (seen !== exp) begin
      n_errors++;
      $display("CHECK FAILED at %0t: %s", $time, msg);
    end
  endtask

  // Bounded wait for the decode phase, seen at a falling edge
  task automatic wait_ready;
    int i;
    for (i = 0; i < 8; i++) begin
      @(negedge i_mclk);
      if (o_instr_ready === 1'b1) return;
    end
    n_errors++;
    $display("CHECK FAILED at %0t: no ready", $time);
    give_verdict();
  endtask

  // Returns {result, n, ov, z, dc, c} of acc + byte + carry
  function automatic logic [12:0] addc(input logic [7:0] w, f,
                                       input logic c);
    logic [8:0] s;
    logic [7:0] r;
    s = {1'b0, w} + {1'b0, f} + {8'h00, c};
    r = s[7:0];
    return {r, r[7], (w[7] == f[7]) && (r[7] != w[7]), r == 8'h00,
            ({1'b0, w[3:0]} + {1'b0, f[3:0]} + {4'h0, c}) > 5'h0f, s[8]};
  endfunction

  task automatic preload(input logic [7:0] w, input logic [4:0] st);
    @(posedge i_mclk);
    i_preset <= 1'b1;
    i_preset_w <= w;
    i_preset_status <= st;
    wait_ready();
    @(posedge i_mclk);
    i_preset <= 1'b0;
  endtask

  // Offers one word, then judges the four phases that follow the take
  task automatic exec(input logic [15:0] ins, input logic [7:0] rdv,
      input logic ext, input logic [3:0] bank, input logic [11:0] fsr,
      input logic [11:0] addr, input logic rd, wr, done,
      input logic [7:0] res, w, input logic [4:0] st);
    @(posedge i_mclk);
    i_instr_valid <= 1'b1;
    i_instr <= ins;
    i_mem_rdata <= rdv;
    i_ext_en <= ext;
    i_bank_select <= bank;
    i_fsr2 <= fsr;
    wait_ready();
    @(posedge i_mclk);
    i_instr_valid <= 1'b0;
    @(negedge i_mclk);
    check(o_mem.rd, rd, "read phase");
    if (rd) check(o_mem.addr, addr, "operand address");
    @(negedge i_mclk);
    check(o_done, 1'b0, "early done");
    @(negedge i_mclk);
    check(o_done, done, "done pulse");
    check(o_mem.wr, wr, "write strobe");
    if (wr) check(o_mem.wdata, res, "written byte");
    @(negedge i_mclk);
    check(o_w, w, "accumulator");
    check(o_status, st, "status flags");
  endtask

  // ****************************************
  // Scenarios
  // ****************************************
  task automatic t_addc_banked;
    preload(8'h4d, 5'h01);
    x = addc(8'h4d, 8'h02, 1'b1);
    exec({6'h08, 2'b01, 8'h02}, 8'h02, 1'b1, 4'h3, 12'h000, 12'h302,
         1'b1, 1'b0, 1'b1, x[12:5], x[12:5], x[4:0]);
  endtask

  task automatic t_addc_to_file;
    preload(8'h7f, 5'h01);
    x = addc(8'h7f, 8'h00, 1'b1);
    exec({6'h08, 2'b10, 8'h80}, 8'h00, 1'b1, 4'h3, 12'h000, 12'hf80,
         1'b1, 1'b1, 1'b1, x[12:5], 8'h7f, x[4:0]);
    preload(8'h01, 5'h00);
    x = addc(8'h01, 8'hff, 1'b0);
    exec({6'h08, 2'b00, 8'h5f}, 8'hff, 1'b1, 4'h3, 12'hfb0, 12'h00f,
         1'b1, 1'b0, 1'b1, x[12:5], x[12:5], x[4:0]);
  endtask

  task automatic t_and_file;
    preload(8'h17, 5'h1f);
    exec({6'h05, 2'b10, 8'h10}, 8'hc2, 1'b0, 4'h3, 12'h800, 12'h010,
         1'b1, 1'b1, 1'b1, 8'h02, 8'h17, 5'h0b);
    preload(8'h0f, 5'h00);
    exec({6'h05, 2'b00, 8'h60}, 8'hf0, 1'b1, 4'h3, 12'h800, 12'hf60,
         1'b1, 1'b0, 1'b1, 8'h00, 8'h00, 5'h04);
  endtask

  task automatic t_and_lit;
    preload(8'ha3, 5'h1f);
    exec({8'h0b, 8'h5f}, 8'hff, 1'b0, 4'h0, 12'h000, 12'h000,
         1'b0, 1'b0, 1'b1, 8'h03, 8'h03, 5'h0b);
    preload(8'hff, 5'h00);
    exec({8'h0b, 8'h80}, 8'h00, 1'b0, 4'h0, 12'h000, 12'h000,
         1'b0, 1'b0, 1'b1, 8'h80, 8'h80, 5'h10);
  endtask

  // Reset in mid-run must restart in decode with cleared state
  task automatic t_reset;
    preload(8'h5a, 5'h1f);
    @(posedge i_mclk);
    i_rst <= 1'b1;
    repeat (2) @(posedge i_mclk);
    i_rst <= 1'b0;
    @(negedge i_mclk);
    check(o_instr_ready, 1'b1, "ready after reset");
    check(o_done, 1'b0, "done after reset");
    check(o_w, alu_pkg::W_RESET, "accumulator reset");
    check(o_status, alu_pkg::STATUS_RESET, "status reset");
    check({o_mem.rd, o_mem.wr}, 2'b00, "strobes after reset");
    check(o_mem.addr, 12'h000, "address after reset");
    check(o_mem.wdata, 8'h00, "write data after reset");
    @(negedge i_mclk);
    check(o_instr_ready, 1'b0, "read phase after reset");
  endtask

  // An unknown opcode still spends a cycle but leaves state alone
  task automatic t_unknown;
    preload(8'h55, 5'h0a);
    exec({6'h3f, 2'b11, 8'h00}, 8'h00, 1'b0, 4'h0, 12'h000, 12'h000,
         1'b0, 1'b0, 1'b0, 8'h00, 8'h55, 5'h0a);
  endtask

  // ****************************************
  // Clock, reset and sequence
  // ****************************************
  initial begin
    i_mclk = 1'b0;
    forever #5 i_mclk = ~i_mclk;
  end

  initial begin
    i_rst = 1'b1;
    i_instr_valid = 1'b0;
    i_instr = '0;
    i_ext_en = 1'b0;
    i_bank_select = '0;
    i_fsr2 = '0;
    i_mem_rdata = 8'h00;
    i_preset = 1'b0;
    i_preset_w = 8'h00;
    i_preset_status = '0;
    repeat (6) @(posedge i_mclk);
    i_rst <= 1'b0;
    t_addc_banked();
    t_addc_to_file();
    t_and_file();
    t_and_lit();
    t_reset();
    t_unknown();
    give_verdict();
  end
endmodule
